// ==== hw/dra_eval.sv ====
// Deviation and rate-of-change alarm evaluator with AXI4-Lite registers.
// Assumes pv_in and centre_wire are synchronous to mclk; one clock only.
`timescale 1ns/1ps
module dra_eval #(
	parameter int TICK_CYCLES_P = dra_pkg::TICK_CYCLES
) (
	input  wire logic                        mclk,
	input  wire logic                        reset,
	input  wire logic [dra_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [dra_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [31:0]                 pv_in,
	input  wire logic                        centre_wire_en,
	input  wire logic [31:0]                 centre_wire,
	output logic                             alarm,
	output logic                             irq
);
	import dra_pkg::*;
	localparam int TW = $clog2(TICK_CYCLES_P);

	if (TICK_CYCLES_P < 64) begin : g_chk
		$error("dra_eval: tick period shorter than one division");
	end

	typedef struct packed {
		logic             aw_have;
		logic [7:0]       aw_addr;
		logic             w_have;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		dra_alm_t         atype;
		logic             block_en;
		logic             supp;
		logic             stby;
		dra_tb_t          tb;
		logic [31:0]      centre;
		logic [31:0]      band;
		logic [31:0]      hyst;
		logic [31:0]      rlimit;
		logic [16:0]      smooth;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic [TW-1:0]    tick_cnt;
		dra_phase_t       phase;
		logic             div_start;
		logic [31:0]      x;
		logic [31:0]      filt;
		logic             hist;
		logic [55:0]      rate;
		logic             raw;
		logic             block;
		logic             alarm;
		logic             irq;
	} dra_state_t;

	dra_state_t  s_q, s_d;
	logic [33:0] div_dvd;
	logic [16:0] div_den;
	logic        div_done;
	logic [33:0] div_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic [31:0] clamp(input logic [31:0] v, input int lo, input int hi);
		if ($signed(v) < lo) return 32'(lo);
		if ($signed(v) > hi) return 32'(hi);
		return v;
	endfunction

	function automatic logic signed [33:0] sx(input logic [31:0] v);
		return $signed({v[31], v[31], v});
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		case ({a[7:2], 2'h0})
			OFF_CTRL, OFF_CENTRE, OFF_BAND, OFF_HYST, OFF_RLIMIT, OFF_SMOOTH,
			OFF_STATUS, OFF_INT_STAT, OFF_INT_MASK, OFF_FILT, OFF_MEAS_RATE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [16:0] rate_mult(input dra_tb_t tb);
		case (tb)
			TB_MIN:  return 17'(TICKS_PER_SEC * SEC_PER_MIN);
			TB_HOUR: return 17'(TICKS_PER_SEC * SEC_PER_HOUR);
			default: return 17'(TICKS_PER_SEC);
		endcase
	endfunction

	function automatic logic [31:0] ctrl_img(input dra_state_t s);
		logic [31:0] r;
		r = '0;
		r[CTRL_TYPE_LSB +: 3] = s.atype;
		r[CTRL_BLOCK]         = s.block_en;
		r[CTRL_SUPP]          = s.supp;
		r[CTRL_STBY]          = s.stby;
		r[CTRL_TB_LSB +: 2]   = s.tb;
		return r;
	endfunction

	// Next-state logic: bus slave, settings, tick, evaluation, interrupts
	always_comb begin
		logic [31:0]        wv;
		logic signed [33:0] xv, hi_thr, lo_thr, hy;
		logic signed [55:0] rate_v, lim;
		logic               set_c, clr_c;
		logic [INT_W-1:0]   ev;
		wv = '0;
		xv = '0;
		hi_thr = '0;
		lo_thr = '0;
		hy = '0;
		rate_v = '0;
		lim = '0;
		set_c = 1'b0;
		clr_c = 1'b0;
		ev = '0;
		s_d = s_q;
		s_d.div_start = 1'b0;
		// Write channels taken independently, answered once both held
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = is_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case ({s_q.aw_addr[7:2], 2'h0})
				OFF_CTRL: begin
					wv = merge(ctrl_img(s_q), s_q.w_data, s_q.w_strb);
					if (wv[CTRL_TYPE_LSB +: 3] <= 3'h5) s_d.atype = dra_alm_t'(wv[CTRL_TYPE_LSB +: 3]);
					s_d.block_en = wv[CTRL_BLOCK];
					s_d.supp = wv[CTRL_SUPP];
					s_d.stby = wv[CTRL_STBY];
					if (wv[CTRL_TB_LSB +: 2] != 2'h3) s_d.tb = dra_tb_t'(wv[CTRL_TB_LSB +: 2]);
				end
				OFF_CENTRE: s_d.centre = clamp(merge(s_q.centre, s_q.w_data, s_q.w_strb), VAL_MIN, VAL_MAX);
				OFF_BAND:   s_d.band = clamp(merge(s_q.band, s_q.w_data, s_q.w_strb), VAL_MIN, VAL_MAX);
				OFF_HYST:   s_d.hyst = clamp(merge(s_q.hyst, s_q.w_data, s_q.w_strb), 0, VAL_MAX);
				OFF_RLIMIT: s_d.rlimit = clamp(merge(s_q.rlimit, s_q.w_data, s_q.w_strb), VAL_MIN, VAL_MAX);
				OFF_SMOOTH: begin
					wv = clamp(merge({15'h0, s_q.smooth}, s_q.w_data, s_q.w_strb), 0, SMOOTH_MAX);
					s_d.smooth = wv[16:0];
				end
				OFF_INT_STAT: if (s_q.w_strb[0]) s_d.int_stat = s_q.int_stat & ~s_q.w_data[INT_W-1:0];
				OFF_INT_MASK: if (s_q.w_strb[0]) s_d.int_mask = s_q.w_data[INT_W-1:0];
				default: ;
			endcase
		end
		// A wired centre source overrides bus writes
		if (centre_wire_en) s_d.centre = clamp(centre_wire, VAL_MIN, VAL_MAX);
		// Read channel, answered one cycle after the address
		if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'h0})
				OFF_CTRL:      s_d.rdata = ctrl_img(s_q);
				OFF_CENTRE:    s_d.rdata = s_q.centre;
				OFF_BAND:      s_d.rdata = s_q.band;
				OFF_HYST:      s_d.rdata = s_q.hyst;
				OFF_RLIMIT:    s_d.rdata = s_q.rlimit;
				OFF_SMOOTH:    s_d.rdata = {15'h0, s_q.smooth};
				OFF_STATUS:    s_d.rdata = {28'h0, s_q.hist, s_q.block, s_q.raw, s_q.alarm};
				OFF_INT_STAT:  s_d.rdata = {29'h0, s_q.int_stat};
				OFF_INT_MASK:  s_d.rdata = {29'h0, s_q.int_mask};
				OFF_FILT:      s_d.rdata = s_q.filt;
				OFF_MEAS_RATE: s_d.rdata = s_q.rate[31:0];
				default:       s_d.rdata = 32'h00000000;
			endcase
		end
		// Update tick divider
		s_d.tick_cnt = (s_q.tick_cnt == '0) ? TW'(TICK_CYCLES_P - 1) : s_q.tick_cnt - 1'b1;
		// One sample and one evaluation per tick
		case (s_q.phase)
			PH_IDLE: begin
				if (s_q.tick_cnt == '0) begin
					s_d.x = pv_in;
					s_d.div_start = 1'b1;
					s_d.phase = PH_DIV;
				end
			end
			PH_DIV: begin
				if (div_done) begin
					s_d.phase = PH_IDLE;
					// First-order smoothing step, 1/(N+1) per tick
					if (!s_q.hist) begin
						s_d.filt = s_q.x;
						s_d.hist = 1'b1;
						rate_v = '0;
					end else begin
						s_d.filt = s_q.filt + div_q[31:0];
						rate_v = $signed(div_q) * $signed({1'b0, rate_mult(s_q.tb)});
					end
					s_d.rate = rate_v;
					lim = $signed({{24{s_q.rlimit[31]}}, s_q.rlimit});
					xv = sx(s_q.x);
					hy = sx(s_q.hyst);
					hi_thr = sx(s_q.centre) + sx(s_q.band);
					lo_thr = sx(s_q.centre) - sx(s_q.band);
					case (s_q.atype)
						ALM_HIGH: begin
							set_c = xv > hi_thr;
							clr_c = xv < hi_thr - hy;
						end
						ALM_LOW: begin
							set_c = xv < lo_thr;
							clr_c = xv > lo_thr + hy;
						end
						ALM_BAND: begin
							set_c = (xv > hi_thr) || (xv < lo_thr);
							clr_c = (xv < hi_thr - hy) && (xv > lo_thr + hy);
						end
						ALM_RISE: begin
							set_c = rate_v > lim;
							clr_c = rate_v < lim;
						end
						ALM_FALL: begin
							set_c = -rate_v > lim;
							clr_c = -rate_v < lim;
						end
						default: begin
							set_c = 1'b0;
							clr_c = 1'b1;
						end
					endcase
					s_d.raw = s_q.raw ? !clr_c : set_c;
					if (!s_d.raw) s_d.block = 1'b0; // Working condition reached
				end
			end
			default: s_d.phase = PH_IDLE;
		endcase
		// Centre change re-arms blocking, after the clear so it wins
		if (s_q.block_en && s_d.centre != s_q.centre) begin
			s_d.block = 1'b1;
			ev[INT_BLK] = 1'b1;
		end
		s_d.alarm = s_d.raw && !(s_d.block && s_q.block_en) && !(s_q.stby && s_q.supp);
		ev[INT_SET] = s_d.alarm && !s_q.alarm;
		ev[INT_CLR] = !s_d.alarm && s_q.alarm;
		// Sticky events: a set in the clearing cycle survives
		s_d.int_stat = s_d.int_stat | ev;
		s_d.irq = |(s_d.int_stat & s_d.int_mask);
	end

	// State register with defaults on reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q        <= '0;
			s_q.atype  <= ALM_OFF;
			s_q.tb     <= dra_tb_t'(TB_RST);
			s_q.centre <= CENTRE_RST;
			s_q.band   <= BAND_RST;
			s_q.hyst   <= HYST_RST;
			s_q.rlimit <= RLIMIT_RST;
			s_q.smooth <= SMOOTH_RST;
			s_q.phase  <= PH_IDLE;
			s_q.block  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Smoothing divider: (sample - filtered) / (period + 1)
	assign div_dvd = sx(s_q.x) - sx(s_q.filt);
	assign div_den = s_q.smooth + 17'h00001;

	dra_div #(.DW(34), .VW(SMOOTH_W)) u_div (
		.mclk     (mclk),
		.reset    (reset),
		.start    (s_q.div_start),
		.dividend (div_dvd),
		.divisor  (div_den),
		.done     (div_done),
		.quotient (div_q)
	);

	// Handshake and result outputs
	assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign alarm         = s_q.alarm;
	assign irq           = s_q.irq;

	// Checks on settings, evaluation outcomes and reset defaults
	logic        ev_now;
	logic [55:0] lim_x;
	assign ev_now = (s_q.phase == PH_DIV) && div_done;
	assign lim_x  = {{24{s_q.rlimit[31]}}, s_q.rlimit};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_standby_quiet: assert property (s_q.stby && s_q.supp |=> !s_q.alarm)
		else $error("alarm active under standby suppress");
	a_high_sets: assert property (ev_now && s_q.atype == ALM_HIGH &&
		sx(s_q.x) > sx(s_q.centre) + sx(s_q.band) |=> s_q.raw)
		else $error("deviation high did not set");
	a_high_holds: assert property (ev_now && s_q.atype == ALM_HIGH && s_q.raw &&
		sx(s_q.x) >= sx(s_q.centre) + sx(s_q.band) - sx(s_q.hyst) |=> s_q.raw)
		else $error("deviation high cleared inside hysteresis");
	a_low_sets: assert property (ev_now && s_q.atype == ALM_LOW &&
		sx(s_q.x) < sx(s_q.centre) - sx(s_q.band) |=> s_q.raw)
		else $error("deviation low did not set");
	a_band_clears: assert property (ev_now && s_q.atype == ALM_BAND &&
		sx(s_q.x) < sx(s_q.centre) + sx(s_q.band) - sx(s_q.hyst) &&
		sx(s_q.x) > sx(s_q.centre) - sx(s_q.band) + sx(s_q.hyst) |=> !s_q.raw && !s_q.block)
		else $error("deviation band did not clear");
	a_centre_range: assert property ($signed(s_q.centre) >= VAL_MIN &&
		$signed(s_q.centre) <= VAL_MAX)
		else $error("centre out of range");
	a_block_rearm: assert property ($changed(s_q.centre) && $past(s_q.block_en) |->
		s_q.block && !s_q.alarm)
		else $error("centre change did not re-arm blocking");
	a_rise_sets: assert property (ev_now && s_q.atype == ALM_RISE && s_q.hist |=>
		(($signed(s_q.rate) > $signed($past(lim_x))) |-> s_q.raw))
		else $error("rising rate did not set");
	a_rate_holds: assert property (ev_now && s_q.atype == ALM_RISE && s_q.raw |=>
		(($signed(s_q.rate) >= $signed($past(lim_x))) |-> s_q.raw))
		else $error("rate alarm cleared at or above limit");
	a_tb_legal: assert property (s_q.tb != dra_tb_t'(2'h3))
		else $error("illegal time base");
	a_tick_eval: assert property (s_q.phase == PH_IDLE && s_q.tick_cnt == '0 |->
		##[36:38] $fell(s_q.phase == PH_DIV))
		else $error("evaluation not finished in time");
	a_reset_defaults: assert property ($past(reset) |-> s_q.centre == CENTRE_RST &&
		!s_q.alarm && !s_q.hist)
		else $error("reset defaults wrong");

	c_alarm_rise: cover property (!s_q.alarm ##1 s_q.alarm);
	c_block_rearm: cover property (s_q.block_en && $changed(s_q.centre));
	c_roc_alarm: cover property (s_q.atype == ALM_FALL && s_q.alarm);
endmodule

// ==== hw/dra_pkg.sv ====
// Shared constants and types for the deviation and rate alarm evaluator.
// Assumes a 10 MHz clock and 32-bit AXI4-Lite register access.
package dra_pkg;
	// Register byte offsets
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CENTRE    = 8'h04;
	localparam logic [7:0]  OFF_BAND      = 8'h08;
	localparam logic [7:0]  OFF_HYST      = 8'h0C;
	localparam logic [7:0]  OFF_RLIMIT    = 8'h10;
	localparam logic [7:0]  OFF_SMOOTH    = 8'h14;
	localparam logic [7:0]  OFF_STATUS    = 8'h18;
	localparam logic [7:0]  OFF_INT_STAT  = 8'h1C;
	localparam logic [7:0]  OFF_INT_MASK  = 8'h20;
	localparam logic [7:0]  OFF_FILT      = 8'h24;
	localparam logic [7:0]  OFF_MEAS_RATE = 8'h28;
	// Control register fields
	localparam int          CTRL_TYPE_LSB = 0;
	localparam int          CTRL_BLOCK    = 3;
	localparam int          CTRL_SUPP     = 4;
	localparam int          CTRL_STBY     = 5;
	localparam int          CTRL_TB_LSB   = 8;
	// Status and interrupt bits
	localparam int          ST_ALARM      = 0;
	localparam int          ST_RAW        = 1;
	localparam int          ST_BLOCK      = 2;
	localparam int          ST_HIST       = 3;
	localparam int          INT_W         = 3;
	localparam int          INT_SET       = 0;
	localparam int          INT_CLR       = 1;
	localparam int          INT_BLK       = 2;
	// Reset values, tenths of a unit
	localparam logic [31:0] CENTRE_RST    = 32'h0000000A;
	localparam logic [31:0] BAND_RST      = 32'h0000000A;
	localparam logic [31:0] HYST_RST      = 32'h00000000;
	localparam logic [31:0] RLIMIT_RST    = 32'h0000000A;
	localparam logic [16:0] SMOOTH_RST    = 17'h00000;
	localparam logic [1:0]  TB_RST        = 2'h0;
	// Setting ranges, tenths
	localparam int          VAL_MIN       = -199990;
	localparam int          VAL_MAX       = 999990;
	localparam int          SMOOTH_MAX    = 99999;
	localparam int          SMOOTH_W      = 17;
	// Timing
	localparam int          CLK_HZ        = 10_000_000;
	localparam int          TICK_PERIOD_MS = 100;
	localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int          TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;
	localparam int          SEC_PER_MIN   = 60;
	localparam int          SEC_PER_HOUR  = 3600;
	// Bus answers
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {ALM_OFF, ALM_HIGH, ALM_LOW, ALM_BAND, ALM_RISE, ALM_FALL} dra_alm_t;
	typedef enum logic [1:0] {TB_SEC, TB_MIN, TB_HOUR} dra_tb_t;
	typedef enum logic {PH_IDLE, PH_DIV} dra_phase_t;
endpackage

// ==== hw/dra_div.sv ====
// Serial signed-by-unsigned divider, one quotient bit per clock.
// Assumes a non-zero divisor and that start is only raised while idle.
`timescale 1ns/1ps
module dra_div #(
	parameter int DW = 34,
	parameter int VW = 17
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          start,
	input  wire logic [DW-1:0] dividend,
	input  wire logic [VW-1:0] divisor,
	output logic               done,
	output logic [DW-1:0]      quotient
);
	import dra_pkg::*;
	localparam int CW = $clog2(DW + 1);

	if (DW < 2 || VW < 1) begin : g_chk
		$error("dra_div: widths too small");
	end

	typedef struct packed {
		logic          busy;
		logic          done;
		logic          neg;
		logic [CW-1:0] cnt;
		logic [VW:0]   rem;
		logic [DW-1:0] acc;
		logic [VW-1:0] den;
		logic [DW-1:0] quo;
	} dra_div_st_t;

	dra_div_st_t s_q, s_d;

	// Restoring division on the magnitude, sign applied at the end
	always_comb begin
		logic [VW:0] trial;
		trial = '0;
		s_d = s_q;
		s_d.done = 1'b0;
		if (start && !s_q.busy) begin
			s_d.busy = 1'b1;
			s_d.neg  = dividend[DW-1];
			s_d.acc  = dividend[DW-1] ? (~dividend + 1'b1) : dividend;
			s_d.den  = divisor;
			s_d.rem  = '0;
			s_d.cnt  = CW'(DW);
		end else if (s_q.busy) begin
			trial = {s_q.rem[VW-1:0], s_q.acc[DW-1]};
			s_d.acc = {s_q.acc[DW-2:0], 1'b0};
			if (trial >= {1'b0, s_q.den}) begin
				s_d.rem = trial - {1'b0, s_q.den};
				s_d.acc[0] = 1'b1;
			end else begin
				s_d.rem = trial;
			end
			s_d.cnt = s_q.cnt - 1'b1;
			if (s_q.cnt == CW'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.quo  = s_q.neg ? (~s_d.acc + 1'b1) : s_d.acc;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done     = s_q.done;
	assign quotient = s_q.quo;
endmodule

// ==== testbench/dra_pv_src.sv ====
// Process input source: holds a level and ramps it once per update period.
// Assumes its period equals the evaluator's tick and both leave reset together.
`timescale 1ns/1ps
module dra_pv_src #(
	parameter int P = 100
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        load,
	input  wire logic [31:0] level,
	input  wire logic [31:0] ramp,
	output logic [31:0]      pv_in
);
	int cnt;

	// Step on the tick edge, so every sample sees exactly one whole step
	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt <= 0;
			pv_in <= 32'h0;
		end else begin
			cnt <= (cnt == P - 1) ? 0 : cnt + 1;
			if (load)
				pv_in <= level;
			else if (cnt == 0)
				pv_in <= pv_in + ramp;
		end
	end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the deviation and rate alarm evaluator.
// Assumes a short tick so that every evaluation lands within three ticks.
`timescale 1ns/1ps
module tb;
	import dra_pkg::*;
	localparam int TK = 100;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dra_exp_t;
	logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready, cw_en, load;
	logic        awready, wready, bvalid, arready, rvalid, alarm, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, pv, cw, level, ramp;
	logic [1:0]  bresp, rresp;
	dra_exp_t    q[$];
	dra_exp_t    e;
	int          error_cnt, n_compared, i;
	logic [7:0]  ca [6] = '{OFF_CENTRE, OFF_CENTRE, OFF_BAND, OFF_BAND, OFF_SMOOTH, OFF_SMOOTH};
	logic [31:0] cd [6] = '{32'h7FFFFFFF, 32'h80000000, 32'h7FFFFFFF, 32'h80000000,
		32'h0001FFFF, 32'hFFFFFFFB};
	logic [31:0] ce [6] = '{32'h000F4236, 32'hFFFCF2CA, 32'h000F4236, 32'hFFFCF2CA,
		32'h0001869F, 32'h0};
	logic [2:0]  dt [14] = '{1, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 3, 3};
	logic [31:0] dp [14] = '{32'h97, 32'h8C, 32'h82, 32'h81, 32'h96, 32'h31, 32'h3C,
		32'h47, 32'h97, 32'h8C, 32'h64, 32'h31, 32'h45, 32'h47};
	logic        de [14] = '{1, 1, 1, 0, 0, 1, 1, 0, 1, 1, 0, 1, 1, 0};
	logic [31:0] re [3] = '{32'hA, 32'h258, 32'h8CA0};

	dra_eval #(.TICK_CYCLES_P(TK)) uut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pv_in(pv), .centre_wire_en(cw_en), .centre_wire(cw),
		.alarm(alarm), .irq(irq));
	dra_pv_src #(.P(TK)) src (.mclk(mclk), .reset(reset), .load(load), .level(level),
		.ramp(ramp), .pv_in(pv));

	// Clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic fail(input string s);
		error_cnt++;
		$display("wrong value at %0t: %s", $time, s);
	endtask

	task automatic chk(input logic [31:0] a, input logic [31:0] b, input string s);
		n_compared++;
		if (a !== b)
			fail(s);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 1000);
		if (n >= 1000) begin
			fail("write hang");
			test_done();
		end
		chk(32'(bresp), 32'(r), "write response");
	endtask

	// Bus read: the expected word is noted for the watcher before the request
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		q.push_back('{d, m, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 1000);
		if (n >= 1000) begin
			fail("read hang");
			test_done();
		end
	endtask

	task automatic pvs(input logic [31:0] v);
		level <= v;
		load <= 1'b1;
		@(posedge mclk);
		load <= 1'b0;
		cyc(3 * TK);
	endtask

	// Watcher: each read answer is compared with the oldest note
	always @(posedge mclk) begin
		if (rvalid && rready) begin
			if (q.size() == 0) begin
				fail("unexpected read");
			end else begin
				e = q.pop_front();
				n_compared++;
				if ((rdata & e.m) !== e.d || rresp !== e.r)
					fail("read data");
			end
		end
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, cw_en, load} = 7'h0;
		{awaddr, araddr, wdata, cw, level, ramp} = '0;
		error_cnt = 0;
		n_compared = 0;
		i = $urandom(32'h30CD);
		cyc(2);
		reset <= 1'b0;
		@(posedge mclk);
		rd(OFF_STATUS, 32'h0, 32'h9);
		rd(OFF_CTRL, 32'h0, 32'h33F);
		rd(OFF_CENTRE, 32'hA);
		rd(OFF_BAND, 32'hA);
		rd(OFF_RLIMIT, 32'hA);
		rd(OFF_SMOOTH, 32'h0);
		rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(8'h40, 32'h1, RESP_SLVERR);
		// Setting limits
		for (i = 0; i < 6; i++) begin
			wr(ca[i], cd[i]);
			rd(ca[i], ce[i]);
		end
		wr(OFF_SMOOTH, 32'h0);
		wr(OFF_CENTRE, 32'h64);
		wr(OFF_BAND, 32'h32);
		wr(OFF_HYST, 32'h14);
		// Deviation high, low and band with hysteresis edges
		for (i = 0; i < 14; i++) begin
			wr(OFF_CTRL, {29'h0, dt[i]});
			pvs(dp[i]);
			chk(32'(alarm), 32'(de[i]), "deviation alarm");
		end
		// Interrupt raise, clear, mask, and standby suppression
		wr(OFF_INT_STAT, 32'h7);
		wr(OFF_INT_MASK, 32'h1);
		wr(OFF_CTRL, 32'h1);
		pvs(32'hC8 + ($urandom % 500));
		chk(32'(alarm), 32'h1, "alarm high");
		chk(32'(irq), 32'h1, "irq raised");
		wr(OFF_INT_STAT, 32'h1);
		cyc(2);
		chk(32'(irq), 32'h0, "irq cleared");
		wr(OFF_CTRL, 32'h31);
		cyc(3);
		chk(32'(alarm), 32'h0, "suppressed");
		chk(32'(irq), 32'h0, "irq masked");
		rd(OFF_INT_STAT, 32'h2, 32'h7);
		wr(OFF_CTRL, 32'h21);
		cyc(3);
		chk(32'(alarm), 32'h1, "standby alone");
		// Centre change from the wire re-arms blocking
		wr(OFF_CTRL, 32'h9);
		cw <= 32'h78;
		cw_en <= 1'b1;
		cyc(3);
		chk(32'(alarm), 32'h0, "blocked");
		rd(OFF_INT_STAT, 32'h4, 32'h4);
		pvs(32'h64);
		pvs(32'hB4 + ($urandom % 300));
		chk(32'(alarm), 32'h1, "unblocked");
		repeat (3 * TK) begin
			@(posedge mclk);
			cw <= cw ^ 32'h1;
		end
		chk(32'(alarm), 32'h0, "noisy centre");
		cw_en <= 1'b0;
		// Rate of change per time base
		wr(OFF_CTRL, 32'h4);
		cyc(3 * TK);
		ramp <= 32'h1;
		for (i = 0; i < 3; i++) begin
			wr(OFF_CTRL, 32'h4 | 32'(i << CTRL_TB_LSB));
			cyc(3 * TK);
			rd(OFF_MEAS_RATE, re[i]);
			chk(32'(alarm), 32'(i != 0), "rate alarm");
		end
		wr(OFF_CTRL, 32'h4);
		cyc(3 * TK);
		chk(32'(alarm), 32'h1, "rate at limit holds");
		ramp <= 32'h0;
		cyc(3 * TK);
		chk(32'(alarm), 32'h0, "rate cleared");
		wr(OFF_CTRL, 32'h5);
		ramp <= 32'h2;
		cyc(3 * TK);
		chk(32'(alarm), 32'h0, "fall on rise");
		ramp <= 32'hFFFFFFFE;
		cyc(3 * TK);
		chk(32'(alarm), 32'h1, "fall alarm");
		test_done();
	end
endmodule
